// ===== ebrwt_pkg.sv
// constants and carriers for the external bus release and wait-timing block
// assumes one clock, which serves as the interface timing clock
package ebrwt_pkg;

   // ------------------------------------------------------------
   // widths
   // ------------------------------------------------------------
   localparam int LEAD_W = 2;
   localparam int ACT_W = 3;
   localparam int TRAIL_W = 2;
   localparam int CNT_W = 5;
   localparam int WS_W = 8;
   localparam int ADDR_W = 20;
   localparam int DATA_W = 32;
   localparam int ZONE_N = 3;

   // ------------------------------------------------------------
   // timing and reset values
   // ------------------------------------------------------------
   localparam logic [CNT_W-1:0] SYNC_SAMPLE_OFS = 5'h01;
   localparam logic [CNT_W-1:0] ASYNC_SAMPLE_OFS = 5'h03;
   localparam logic [CNT_W-1:0] ONE_CYCLE = 5'h01;
   localparam logic RELEASE_EN_RST = 1'b1;
   localparam logic [1:0] ZONE_A = 2'h0;
   localparam logic [1:0] ZONE_B = 2'h1;
   localparam logic [1:0] ZONE_C = 2'h2;

   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef struct packed {
      logic double_timing;
      logic ready_sampling_enable;
      logic ready_sample_async_sel;
      logic [LEAD_W-1:0] read_lead_count;
      logic [ACT_W-1:0] read_active_count;
      logic [TRAIL_W-1:0] read_trail_count;
      logic [LEAD_W-1:0] write_lead_count;
      logic [ACT_W-1:0] write_active_count;
      logic [TRAIL_W-1:0] write_trail_count;
   } ebrwt_zone_tim_t;

   typedef struct packed {
      logic we;
      logic [1:0] zone;
      logic [1:0] half_en;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } ebrwt_req_t;

   typedef enum logic [2:0] {ST_IDLE, ST_LEAD, ST_ACTIVE, ST_TRAIL, ST_HELD} ebrwt_state_t;

endpackage

// ===== ebrwt_sync.sv
// two-flop synchroniser for pin inputs
// assumes the caller reads only q_o; no reset, power-up junk flushes out
`timescale 1ns/10ps
module ebrwt_sync #(
   parameter int W = 1
) (
   input wire logic clk_sys_i,
   input wire logic ce_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   logic [W-1:0] meta_reg;

   // ------------------------------------------------------------
   // unreset sync stages
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (ce_i) begin
         meta_reg <= d_i;
         q_o <= meta_reg;
      end
   end
endmodule

// ===== ebrwt_core.sv
// bus release handshake and per-zone lead/active/trail access sequencer
// assumes clk_sys_i is the interface timing clock; cpu release_request_sync_status cpu_req_i until ack
`timescale 1ns/10ps
module ebrwt_core
   import ebrwt_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic reset_i,
   input wire logic ce_i,
   input wire logic release_enable_i,
   input wire logic release_enable_wr_i,
   input wire logic write_buffer_en_i,
   input wire ebrwt_zone_tim_t [ZONE_N-1:0] zone_timing_i,
   input wire logic cpu_req_i,
   input wire ebrwt_req_t cpu_cmd_i,
   output logic cpu_ack_o,
   output logic cpu_not_ready_o,
   output logic [DATA_W-1:0] cpu_rdata_o,
   input wire logic bus_release_request_n_i,
   output logic bus_release_grant_n_o,
   output logic release_request_sync_status_o,
   output logic release_grant_status_o,
   output logic release_enable_o,
   output logic [WS_W-1:0] ready_inserted_cycles_o,
   input wire logic ext_ready_in_i,
   input wire logic [DATA_W-1:0] ext_data_bus_i,
   output logic [DATA_W-1:0] ext_data_bus_o,
   output logic ext_data_oe_n_o,
   output logic [ADDR_W-1:0] ext_address_bus_o,
   output logic ext_ctrl_oe_n_o,
   output logic write_strobe_low_n_o,
   output logic write_strobe_high_n_o,
   output logic read_strobe_n_o,
   output logic read_write_dir_o,
   output logic zone_a_select_n_o,
   output logic zone_b_select_n_o,
   output logic zone_c_select_n_o
);

   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   logic [DATA_W+1:0] pins_sync;
   logic req_sync;
   logic rdy_sync;
   logic [DATA_W-1:0] din_sync;

   ebrwt_sync #(.W(DATA_W + 2)) u_sync (
      .clk_sys_i(clk_sys_i),
      .ce_i(ce_i),
      .d_i({~bus_release_request_n_i, ext_ready_in_i, ext_data_bus_i}),
      .q_o(pins_sync)
   );
   assign req_sync = pins_sync[DATA_W+1];
   assign rdy_sync = pins_sync[DATA_W];
   assign din_sync = pins_sync[DATA_W-1:0];

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   ebrwt_state_t state_reg, state_next;
   logic [CNT_W-1:0] cnt_reg, cnt_next;
   logic [WS_W-1:0] ws_reg, ws_next;
   logic release_enable_reg;
   logic q_valid_reg;
   ebrwt_req_t q_reg;
   logic done;
   logic buf_acked_reg;
   logic [DATA_W-1:0] rdata_reg;

   // ------------------------------------------------------------
   // zone timing decode
   // ------------------------------------------------------------
   logic [1:0] zidx;
   ebrwt_zone_tim_t tim;
   logic [CNT_W-1:0] lead_base, act_base, trail_base;
   logic [CNT_W-1:0] lead_dur, act_dur, trail_dur;
   logic [CNT_W-1:0] samp_pt;
   logic samp_hit, extend;

   // per-zone timing select; code 3 falls to zone c
   assign zidx = (q_reg.zone > ZONE_C) ? ZONE_C : q_reg.zone;
   assign tim = zone_timing_i[zidx];
   assign lead_base = q_reg.we ? CNT_W'(tim.write_lead_count) : CNT_W'(tim.read_lead_count);
   assign act_base = q_reg.we ? CNT_W'(tim.write_active_count) : CNT_W'(tim.read_active_count);
   assign trail_base = q_reg.we ? CNT_W'(tim.write_trail_count) : CNT_W'(tim.read_trail_count);
   assign lead_dur = tim.double_timing ? CNT_W'(lead_base << 1) : lead_base;
   assign act_dur = CNT_W'((tim.double_timing ? CNT_W'(act_base << 1) : act_base) + ONE_CYCLE);
   assign trail_dur = tim.double_timing ? CNT_W'(trail_base << 1) : trail_base;
   // sample point before end of active
   // mode bit set picks the early sample point
   assign samp_pt = tim.ready_sample_async_sel ? ASYNC_SAMPLE_OFS : SYNC_SAMPLE_OFS;
   assign samp_hit = tim.ready_sampling_enable && (state_reg == ST_ACTIVE) && (cnt_reg == samp_pt);
   assign extend = samp_hit && !rdy_sync;

   // ------------------------------------------------------------
   // release decode and cpu side
   // ------------------------------------------------------------
   logic hold_go, blocked, accept, buffered, ack_next;
   assign hold_go = req_sync && release_enable_reg && !q_valid_reg;
   // block new cycles once request seen while release is enabled
   assign blocked = (req_sync && release_enable_reg) || (state_reg == ST_HELD);
   assign accept = cpu_req_i && !q_valid_reg && !blocked && !cpu_ack_o;
   assign buffered = cpu_cmd_i.we && write_buffer_en_i && !req_sync;
   assign ack_next = (accept && buffered) || (done && !q_reg.we) || (done && q_reg.we && !cpu_ack_o && cpu_req_i
                     && q_reg == cpu_cmd_i && !buf_acked_reg);

   // ------------------------------------------------------------
   // sequencer
   // ------------------------------------------------------------
   // no checking; zero lead or trail fields just skip those phases
   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      ws_next = ws_reg;
      done = 1'b0;
      case (state_reg)
         ST_IDLE: begin
            if (hold_go) begin
               state_next = ST_HELD;
            end else if (q_valid_reg) begin
               ws_next = '0;
               if (lead_dur != '0) begin
                  state_next = ST_LEAD;
                  cnt_next = lead_dur;
               end else begin
                  state_next = ST_ACTIVE;
                  cnt_next = act_dur;
               end
            end
         end
         ST_LEAD: begin
            if (cnt_reg == ONE_CYCLE) begin
               state_next = ST_ACTIVE;
               cnt_next = act_dur;
            end else begin
               cnt_next = cnt_reg - ONE_CYCLE;
            end
         end
         ST_ACTIVE: begin
            if (extend) begin
               ws_next = ws_reg + 8'h01;
            end else if (cnt_reg == ONE_CYCLE) begin
               if (trail_dur != '0) begin
                  state_next = ST_TRAIL;
                  cnt_next = trail_dur;
               end else begin
                  state_next = ST_IDLE;
                  done = 1'b1;
               end
            end else begin
               cnt_next = cnt_reg - ONE_CYCLE;
            end
         end
         ST_TRAIL: begin
            if (cnt_reg == ONE_CYCLE) begin
               state_next = ST_IDLE;
               done = 1'b1;
            end else begin
               cnt_next = cnt_reg - ONE_CYCLE;
            end
         end
         ST_HELD: begin
            if (!req_sync) begin
               state_next = ST_IDLE;
            end
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   // ------------------------------------------------------------
   // pin next values
   // ------------------------------------------------------------
   logic busy_next, act_next, sel_a_next, sel_b_next, sel_c_next;
   logic [1:0] nzone;
   assign busy_next = (state_next == ST_LEAD) || (state_next == ST_ACTIVE) || (state_next == ST_TRAIL);
   assign act_next = (state_next == ST_ACTIVE);
   assign nzone = (q_reg.zone > ZONE_C) ? ZONE_C : q_reg.zone;
   // select low through lead, active and trail
   assign sel_a_next = busy_next && (nzone == ZONE_A);
   assign sel_b_next = busy_next && (nzone == ZONE_B);
   assign sel_c_next = busy_next && (nzone == ZONE_C);

   // ------------------------------------------------------------
   // registers
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         state_reg <= req_sync ? ST_HELD : ST_IDLE;
         bus_release_grant_n_o <= !req_sync;
         release_grant_status_o <= req_sync;
         ext_ctrl_oe_n_o <= req_sync;
         cnt_reg <= '0;
         ws_reg <= '0;
         q_valid_reg <= 1'b0;
         q_reg <= '0;
         buf_acked_reg <= 1'b0;
         cpu_ack_o <= 1'b0;
         cpu_not_ready_o <= 1'b0;
         cpu_rdata_o <= '0;
         release_request_sync_status_o <= 1'b0;
         ready_inserted_cycles_o <= '0;
      end else if (ce_i) begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         ws_reg <= ws_next;
         // all bus outputs floated when granted
         bus_release_grant_n_o <= (state_next != ST_HELD);
         release_grant_status_o <= (state_next == ST_HELD);
         ext_ctrl_oe_n_o <= (state_next == ST_HELD);
         if (accept) begin
            q_valid_reg <= 1'b1;
            q_reg <= cpu_cmd_i;
            buf_acked_reg <= buffered;
         end else if (done) begin
            q_valid_reg <= 1'b0;
         end
         cpu_ack_o <= ack_next;
         cpu_not_ready_o <= cpu_req_i && !ack_next && !cpu_ack_o;
         // with no trail the bus word is still in flight, so take it directly
         if (done && !q_reg.we) begin
            cpu_rdata_o <= (state_reg == ST_ACTIVE) ? din_sync : rdata_reg;
         end
         release_request_sync_status_o <= req_sync;
         if (done) begin
            ready_inserted_cycles_o <= ws_reg;
         end
      end
   end

   // ------------------------------------------------------------
   // release enable and pin registers
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         release_enable_reg <= RELEASE_EN_RST;
         rdata_reg <= '0;
         ext_data_bus_o <= '0;
         ext_data_oe_n_o <= 1'b1;
         ext_address_bus_o <= '0;
         write_strobe_low_n_o <= 1'b1;
         write_strobe_high_n_o <= 1'b1;
         read_strobe_n_o <= 1'b1;
         read_write_dir_o <= 1'b1;
         zone_a_select_n_o <= 1'b1;
         zone_b_select_n_o <= 1'b1;
         zone_c_select_n_o <= 1'b1;
      end else if (ce_i) begin
         if (release_enable_wr_i) begin
            release_enable_reg <= release_enable_i;
         end
         // latch read data on the last active cycle
         if (state_reg == ST_ACTIVE && cnt_reg == ONE_CYCLE && !extend) begin
            rdata_reg <= din_sync;
         end
         ext_data_bus_o <= q_reg.wdata;
         ext_data_oe_n_o <= !(busy_next && q_reg.we);
         ext_address_bus_o <= busy_next ? q_reg.addr : ext_address_bus_o;
         write_strobe_low_n_o <= !(act_next && q_reg.we && q_reg.half_en[0]);
         write_strobe_high_n_o <= !(act_next && q_reg.we && q_reg.half_en[1]);
         read_strobe_n_o <= !(act_next && !q_reg.we);
         read_write_dir_o <= !(busy_next && q_reg.we);
         zone_a_select_n_o <= !sel_a_next;
         zone_b_select_n_o <= !sel_b_next;
         zone_c_select_n_o <= !sel_c_next;
      end
   end

   always_comb begin
      release_enable_o = release_enable_reg;
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   logic [CNT_W+WS_W-1:0] ph_len_reg;
   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         ph_len_reg <= 13'h0001;
      end else if (ce_i) begin
         ph_len_reg <= (state_next == state_reg) ? 13'(ph_len_reg + 13'h0001) : 13'h0001;
      end
   end

   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (reset_i || !ce_i);

   AST_HIZ_GRANT: assert property (!bus_release_grant_n_o |-> ext_ctrl_oe_n_o && ext_data_oe_n_o)
      else $error("bus driven while granted");
   AST_GRANT_DRAINED: assert property ($fell(bus_release_grant_n_o) |-> !$past(q_valid_reg))
      else $error("grant with access queued");
   AST_ENABLE_GATE: assert property (!release_enable_reg && state_reg == ST_IDLE |=> bus_release_grant_n_o)
      else $error("grant while enable cleared");
   AST_NO_ENTRY_HELD: assert property (!bus_release_grant_n_o |=> !$rose(q_valid_reg))
      else $error("access queued while granted");
   AST_STATUS_GRANT: assert property (release_grant_status_o == !bus_release_grant_n_o)
      else $error("grant status mismatch");
   AST_NO_BUF_REQ: assert property (accept && cpu_cmd_i.we && req_sync |=> !cpu_ack_o)
      else $error("write buffered under request");
   AST_LEAD_LEN: assert property (state_reg == ST_LEAD && state_next != ST_LEAD |-> ph_len_reg == 13'(lead_dur))
      else $error("lead length wrong");
   AST_ACT_LEN: assert property (state_reg == ST_ACTIVE && state_next != ST_ACTIVE
                                 |-> ph_len_reg == 13'(act_dur) + 13'(ws_reg))
      else $error("active length wrong");
   AST_TRAIL_LEN: assert property (state_reg == ST_TRAIL && state_next != ST_TRAIL
                                   |-> ph_len_reg == 13'(trail_dur))
      else $error("trail length wrong");
   AST_NO_WS: assert property (state_reg == ST_ACTIVE && !tim.ready_sampling_enable |-> ws_next == 8'h00)
      else $error("waits without ready sampling");
   AST_EXTEND: assert property (extend |=> state_reg == ST_ACTIVE && $stable(cnt_reg))
      else $error("low ready did not extend");
   AST_TRAIL_PINS: assert property (state_reg == ST_TRAIL |-> read_strobe_n_o && write_strobe_low_n_o
                                    && write_strobe_high_n_o)
      else $error("strobe low in trail");
   AST_UNGRANT: assert property ($rose(bus_release_grant_n_o) |-> !ext_ctrl_oe_n_o && state_reg == ST_IDLE)
      else $error("ungrant without bus drive");
   AST_RST_EN: assert property ($past(reset_i) |-> release_enable_reg)
      else $error("enable not set after reset");

   CV_GRANT: cover property ($fell(bus_release_grant_n_o));
   CV_WAIT: cover property (extend ##1 !extend);
   CV_BUF_WR: cover property (accept && buffered);
   CV_UNGRANT: cover property ($rose(bus_release_grant_n_o) ##[1:4] state_reg == ST_LEAD);

endmodule

// ===== ebrwt_ext_model.sv
// far side model: external memory with slow ready and a dma master wanting the bus
// assumes the bench sets wait depth and hold wish between accesses
`timescale 1ns/10ps
module ebrwt_ext_model
   import ebrwt_pkg::*;
#(
   parameter logic [DATA_W-1:0] READ_PATTERN = 32'hA5C3_0F96
) (
   input wire logic clk_sys_i,
   input wire logic hold_wish_i,
   input wire logic [7:0] wait_depth_i,
   input wire logic bus_release_grant_n_i,
   input wire logic read_strobe_n_i,
   input wire logic write_strobe_low_n_i,
   output logic bus_release_request_n_o,
   output logic ext_ready_in_o,
   output logic [DATA_W-1:0] ext_data_bus_o
);
   logic [7:0] low_cnt_reg = 8'h00;
   logic hold_keep_reg = 1'b0;
   logic [DATA_W-1:0] junk_reg = 32'h0F0F_5AA5;
   always @(posedge clk_sys_i) begin
      if (hold_wish_i) begin
         hold_keep_reg <= 1'b1;
      end else if (!bus_release_grant_n_i) begin
         hold_keep_reg <= 1'b0;
      end
      low_cnt_reg <= (!read_strobe_n_i || !write_strobe_low_n_i) ? low_cnt_reg + 8'h01 : 8'h00;
      junk_reg <= ~junk_reg;
   end
   assign bus_release_request_n_o = !(hold_wish_i || hold_keep_reg);
   // ready low for the first wait_depth strobe cycles
   assign ext_ready_in_o = (low_cnt_reg >= wait_depth_i);
   // undriven bus toggles so stale data never looks valid
   assign ext_data_bus_o = !read_strobe_n_i ? READ_PATTERN : junk_reg;
endmodule

// ===== ebrwt_bench.sv
// self-checking bench for the bus release and wait-timing core
// assumes ebrwt_ext_model on the pins; all inputs but the zone timing move on rising edges
`timescale 1ns/10ps
module ext_bus_release_and_wait_timing_bench
   import ebrwt_pkg::*;
;
   localparam logic [DATA_W-1:0] PAT = 32'hA5C3_0F96;
   localparam logic [DATA_W-1:0] WDAT = 32'hC0DE_1234;
   logic clk_sys_i = 1'b0, reset_i = 1'b1, rel_en = 1'b1, rel_en_wr = 1'b0, wbuf = 1'b0;
   logic cpu_req = 1'b0, hold_wish = 1'b0, req_n, ack, nrdy, grant_n, sync_st, grant_st, en_o, ready;
   logic doe_n, coe_n, wl_n, wh_n, rd_n, dir, sa_n, sb_n, sc_n;
   logic [7:0] wait_depth = 8'h00, ws;
   logic [DATA_W-1:0] rdata, dbus_in, dbus_out;
   logic [ADDR_W-1:0] addr;
   ebrwt_zone_tim_t [ZONE_N-1:0] zt = '0;
   ebrwt_req_t cmd = '0;
   int num_errors = 0, checked = 0, cycles = 0, ack_cnt = 0;
   ebrwt_core dut_u (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .ce_i(1'b1), .release_enable_i(rel_en),
      .release_enable_wr_i(rel_en_wr), .write_buffer_en_i(wbuf), .zone_timing_i(zt), .cpu_req_i(cpu_req),
      .cpu_cmd_i(cmd), .cpu_ack_o(ack), .cpu_not_ready_o(nrdy), .cpu_rdata_o(rdata),
      .bus_release_request_n_i(req_n), .bus_release_grant_n_o(grant_n), .release_request_sync_status_o(sync_st),
      .release_grant_status_o(grant_st), .release_enable_o(en_o), .ready_inserted_cycles_o(ws),
      .ext_ready_in_i(ready), .ext_data_bus_i(dbus_in), .ext_data_bus_o(dbus_out), .ext_data_oe_n_o(doe_n),
      .ext_address_bus_o(addr), .ext_ctrl_oe_n_o(coe_n), .write_strobe_low_n_o(wl_n),
      .write_strobe_high_n_o(wh_n), .read_strobe_n_o(rd_n), .read_write_dir_o(dir),
      .zone_a_select_n_o(sa_n), .zone_b_select_n_o(sb_n), .zone_c_select_n_o(sc_n));
   ebrwt_ext_model #(.READ_PATTERN(PAT)) far_u (.clk_sys_i(clk_sys_i), .hold_wish_i(hold_wish),
      .wait_depth_i(wait_depth), .bus_release_grant_n_i(grant_n), .read_strobe_n_i(rd_n),
      .write_strobe_low_n_i(wl_n), .bus_release_request_n_o(req_n), .ext_ready_in_o(ready),
      .ext_data_bus_o(dbus_in));
   initial begin
      forever #5 clk_sys_i = ~clk_sys_i;
   end
   // ------------------------------------------------------------
   // checking and closing
   // ------------------------------------------------------------
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic final_report();
      $display("checks %0d errors %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   // ceiling well above the few hundred cycles the run needs
   always @(posedge clk_sys_i) begin
      cycles <= cycles + 1;
      if (ack === 1'b1) begin
         ack_cnt <= ack_cnt + 1;
      end
      if (cycles == 20000) begin
         num_errors++;
         final_report();
      end
   end
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   // one access, phases measured on the pins
   task automatic acc(input logic [1:0] zone, input logic we, input int dly);
      ebrwt_zone_tim_t t;
      int mul, ld, ac, tr, bad, n;
      logic sel_n;
      t = zt[zone];
      mul = t.double_timing ? 2 : 1;
      ld = 0; ac = 0; tr = 0; bad = 0; n = 0;
      @(posedge clk_sys_i);
      wait_depth <= dly[7:0];
      cmd <= '{we, zone, 2'h3, 20'h5A3C1, WDAT};
      cpu_req <= 1'b1;
      do begin
         @(negedge clk_sys_i);
         n++;
         sel_n = (zone == ZONE_A) ? sa_n : (zone == ZONE_B) ? sb_n : sc_n;
         if ((~{sc_n, sb_n, sa_n} & ~(3'h1 << zone)) !== 3'h0) bad++;
         if (sel_n === 1'b0) begin
            if (rd_n === 1'b0 || wl_n === 1'b0) ac++;
            else if (ac == 0) ld++;
            else tr++;
            if (we && ac > 0 && tr == 0 && {dbus_out, doe_n, dir, wh_n} !== {WDAT, 3'h0}) bad++;
            if (!we && dir !== 1'b1) bad++;
         end
      end while (ack !== 1'b1 && n < 200);
      @(posedge clk_sys_i);
      cpu_req <= 1'b0;
      check("lead", ld, mul * (we ? t.write_lead_count : t.read_lead_count));
      check("active", ac, mul * (we ? t.write_active_count : t.read_active_count) + 1 + ws);
      check("trail", tr, mul * (we ? t.write_trail_count : t.read_trail_count));
      check("pins", bad, 0);
      check("waits", ws != 8'h00, t.ready_sampling_enable && dly > 0);
      if (!we && ac >= 3) check("read data", rdata, PAT);
   endtask
   task automatic t_timing();
      acc(ZONE_A, 1'b0, 20);
      acc(ZONE_A, 1'b1, 0);
      acc(ZONE_B, 1'b0, 0);
      acc(ZONE_B, 1'b1, 12);
      acc(ZONE_C, 1'b0, 16);
      acc(ZONE_C, 1'b1, 16);
   endtask
   task automatic t_release();
      int n, early, a0;
      early = 0; n = 0;
      @(posedge clk_sys_i);
      cmd <= '{1'b0, ZONE_A, 2'h3, 20'h00010, WDAT};
      cpu_req <= 1'b1;
      hold_wish <= 1'b1;
      do begin
         @(negedge clk_sys_i);
         n++;
         if (grant_n !== 1'b1) early++;
      end while (ack !== 1'b1 && n < 200);
      @(posedge clk_sys_i);
      cpu_req <= 1'b0;
      for (n = 0; n < 10 && grant_n !== 1'b0; n++) @(negedge clk_sys_i);
      check("grant before drain", early, 0);
      check("float", {grant_n, coe_n, doe_n}, 3'h3);
      check("status", {sync_st, grant_st}, 2'h3);
      @(posedge clk_sys_i);
      wbuf <= 1'b1;
      cmd <= '{1'b1, ZONE_B, 2'h3, 20'h00020, WDAT};
      cpu_req <= 1'b1;
      a0 = ack_cnt;
      repeat (12) @(negedge clk_sys_i);
      check("stall", {nrdy, ack_cnt == a0}, 2'h3);
      @(posedge clk_sys_i);
      hold_wish <= 1'b0;
      for (n = 0; n < 12 && grant_n !== 1'b1; n++) @(negedge clk_sys_i);
      check("resume", {grant_n, coe_n, sync_st, ack_cnt == a0}, 4'h9);
      for (n = 0; n < 100 && ack !== 1'b1; n++) @(negedge clk_sys_i);
      check("blocked write", ack, 1'b1);
      @(posedge clk_sys_i);
      cpu_req <= 1'b0;
      wbuf <= 1'b0;
      repeat (30) @(posedge clk_sys_i);
   endtask
   task automatic t_disable();
      int n;
      @(posedge clk_sys_i);
      rel_en <= 1'b0;
      rel_en_wr <= 1'b1;
      @(posedge clk_sys_i);
      rel_en_wr <= 1'b0;
      hold_wish <= 1'b1;
      repeat (20) @(negedge clk_sys_i);
      check("enable cleared", {en_o, grant_n}, 2'h1);
      acc(ZONE_C, 1'b1, 0);
      // request still low across a reset
      @(posedge clk_sys_i);
      reset_i <= 1'b1;
      repeat (3) @(negedge clk_sys_i);
      check("grant in reset", grant_n, 1'b0);
      @(posedge clk_sys_i);
      reset_i <= 1'b0;
      hold_wish <= 1'b0;
      @(negedge clk_sys_i);
      check("enable after reset", en_o, 1'b1);
      for (n = 0; n < 12 && grant_n !== 1'b1; n++) @(negedge clk_sys_i);
      check("grant ends", grant_n, 1'b1);
   endtask
   // ------------------------------------------------------------
   // main sequence
   // ------------------------------------------------------------
   initial begin
      zt[0] = '{1'h0, 1'h0, 1'h0, 2'h2, 3'h6, 2'h0, 2'h3, 3'h1, 2'h3};
      zt[1] = '{1'h1, 1'h1, 1'h0, 2'h1, 3'h3, 2'h1, 2'h2, 3'h1, 2'h2};
      zt[2] = '{1'h0, 1'h1, 1'h1, 2'h2, 3'h6, 2'h0, 2'h3, 3'h4, 2'h3};
      repeat (20) @(posedge clk_sys_i);
      reset_i <= 1'b0;
      @(negedge clk_sys_i);
      check("reset pins", {en_o, grant_n, coe_n, doe_n}, 4'hD);
      t_timing();
      t_release();
      t_disable();
      // all-zero timing still runs
      zt[0] = '0;
      acc(ZONE_A, 1'b0, 0);
      final_report();
   end
endmodule
